// [irq_delivery_defines.svh]
// offsets, field positions and reset values of the interrupt delivery block
// ==========================================================================
`ifndef IRQ_DELIVERY_DEFINES_SVH
`define IRQ_DELIVERY_DEFINES_SVH
// ==========================================================================
// source numbering
`define NUM_SRC 25
`define NUM_EXT 16
`define SRC_DIR_LO 16
`define NUM_DIR 8
`define SRC_ERR 24
`define ISR_W 40
`define ISR_SRC_LSB 15
// ==========================================================================
// register byte offsets
`define OFS_DEST_BASE 12'h080
`define OFS_TASK0 12'h100
`define OFS_TASK1 12'h104
`define OFS_ACK0 12'h108
`define OFS_ACK1 12'h10c
`define OFS_EOI0 12'h110
`define OFS_EOI1 12'h114
`define OFS_IPI 12'h118
`define OFS_STATUS 12'h11c
`define OFS_ISR0_SRC 12'h120
`define OFS_ISR1_SRC 12'h124
`define OFS_ISR0_PRI 12'h128
`define OFS_ISR1_PRI 12'h12c
`define OFS_SPUR 12'h130
// ==========================================================================
// vector-priority word fields
`define VP_MASK_BIT 31
`define VP_POL_BIT 23
`define VP_SENSE_BIT 22
`define VP_PRI_LSB 16
`define VP_VEC_LSB 0
// ==========================================================================
// reset values
`define RST_MASK 1'b1
`define RST_DEST 2'b01
`define RST_TASK 4'hf
`define RST_SPUR 8'hff
`endif

// [irq_delivery_pkg.sv]
// types shared by the interrupt delivery block
package irq_delivery_pkg;
   typedef logic [3:0] pri_t;
   typedef logic [4:0] src_t;
   // one selector result: valid, source, priority
   typedef struct packed {
      logic valid;
      src_t src;
      pri_t pri;
   } pick_t;
   typedef enum logic [1:0] {
      RESP_OKAY = 2'b00,
      RESP_SLVERR = 2'b10
   } axi_resp_t;
endpackage : irq_delivery_pkg

// [irq_delivery.sv]
// interrupt delivery datapath for two processors with an AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "irq_delivery_defines.svh"
module irq_delivery (
   // clock and reset
   input wire logic CLK,
   input wire logic ARST_N,
   // axi4-lite write address
   input wire logic [11:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   // axi4-lite write data
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   // axi4-lite write response
   output irq_delivery_pkg::axi_resp_t BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // axi4-lite read
   input wire logic [11:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output irq_delivery_pkg::axi_resp_t RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // interrupt sources
   input wire logic [15:0] EXT_IRQ,
   input wire logic [3:0] TIMER_EVT,
   input wire logic ERR_IRQ,
   // processor interrupt outputs
   output logic [1:0] IRQ_OUT
);
   import irq_delivery_pkg::*;

   // ==========================================================================
   // helpers
   // highest priority requester; strict compare keeps the lowest id on a tie
   function automatic pick_t pick(input logic [24:0] req, input logic [24:0][3:0] pri);
      pick_t r;
      r = '0;
      for (int s = 0; s < `NUM_SRC; s++) begin
         if (req[s] && (!r.valid || pri[s] > r.pri)) begin
            r.valid = 1'b1;
            r.src = 5'(s);
            r.pri = pri[s];
         end
      end
      return r;
   endfunction : pick

   // highest in-service priority level, 0 when idle
   function automatic pri_t top_pri(input logic [14:0] lv);
      pri_t p;
      p = '0;
      for (int i = 0; i < 15; i++) begin
         if (lv[i]) begin
            p = 4'(i + 1);
         end
      end
      return p;
   endfunction : top_pri

   // byte-lane merge of a write into an old word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] st);
      logic [31:0] m;
      m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
      return (old & ~m) | (wd & m);
   endfunction : merge

   // ==========================================================================
   // configuration state
   logic [24:0] mask_q;              // source mask
   logic [24:0] pol_q;               // 1 = active high / rising
   logic [24:0] sense_q;             // 1 = level, 0 = edge
   logic [24:0][3:0] pri_q;          // source priority
   logic [24:0][7:0] vec_q;          // source vector
   logic [24:0][1:0] dest_q;         // destination bit per processor
   pri_t task_q [2];                 // current task priority
   logic [7:0] spur_q;               // vector for a stale acknowledge

   // ==========================================================================
   // delivery state
   logic [15:0] ext_pend_q;          // distributed pending, external
   logic [15:0] ext_prev_q;          // previous active level, edge detect
   logic err_pend_q;                 // distributed pending, error source
   logic err_prev_q;
   logic [1:0][7:0] dir_pend_q;      // direct pending, one set per processor
   pick_t st_q [2];                  // selector first stage
   pick_t hold_q [2];                // request hold register
   logic [1:0][39:0] isr_q;          // in-service tracker

   // ==========================================================================
   // bus state
   logic aw_v_q, w_v_q, bvalid_q, rvalid_q;
   logic [11:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic [31:0] rdata_q;
   logic do_wr, ar_hs;

   assign AWREADY = !aw_v_q && !bvalid_q;
   assign WREADY = !w_v_q && !bvalid_q;
   assign BVALID = bvalid_q;
   assign BRESP = RESP_OKAY;
   assign ARREADY = !rvalid_q;
   assign RVALID = rvalid_q;
   assign RRESP = RESP_OKAY;
   assign RDATA = rdata_q;
   assign do_wr = aw_v_q && w_v_q && !bvalid_q;
   assign ar_hs = ARVALID && !rvalid_q;

   // ==========================================================================
   // requests, selection and acknowledge decode
   logic [15:0] ext_act;             // external level in active sense
   logic [1:0][24:0] req;            // qualified requests per processor
   pick_t sel [2];                   // combinational selector output
   pick_t eoi_pick [2];              // completion pick from tracker
   logic [1:0] ack_ok, eoi_wr;
   logic [24:0] clr_dist;            // distributed pending clears
   logic ipi_wr;

   // external qualification by polarity; sense is applied in the pending latch
   always_comb begin
      for (int s = 0; s < `NUM_EXT; s++) begin
         ext_act[s] = pol_q[s] ? EXT_IRQ[s] : !EXT_IRQ[s];
      end
   end

   // request vectors: a zero priority can never win delivery
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         for (int s = 0; s < `NUM_SRC; s++) begin
            if (s >= `SRC_DIR_LO && s < `SRC_ERR) begin
               req[c][s] = dir_pend_q[c][s - `SRC_DIR_LO];
            end else if (s == `SRC_ERR) begin
               req[c][s] = err_pend_q && dest_q[s][c];
            end else begin
               req[c][s] = ext_pend_q[s] && dest_q[s][c];
            end
            req[c][s] = req[c][s] && !mask_q[s] && (pri_q[s] != 4'h0);
         end
      end
   end

   // one selector per processor, second input set from the tracker
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         sel[c] = pick(req[c], pri_q);
         eoi_pick[c] = pick(isr_q[c][39:15], pri_q);
      end
   end

   // acknowledge only counts if the held source is still requesting;
   // a level dropped or a mask raised in between yields the stale vector
   always_comb begin
      clr_dist = '0;
      for (int c = 0; c < 2; c++) begin
         ack_ok[c] = ar_hs && (ARADDR == ((c == 0) ? `OFS_ACK0 : `OFS_ACK1)) &&
                     hold_q[c].valid && req[c][hold_q[c].src];
         eoi_wr[c] = do_wr && (aw_addr_q == ((c == 0) ? `OFS_EOI0 : `OFS_EOI1));
         if (ack_ok[c]) begin
            clr_dist[hold_q[c].src] = 1'b1;
         end
      end
      ipi_wr = do_wr && (aw_addr_q == `OFS_IPI);
   end

   // ==========================================================================
   // pending latch, distributed sources; a new event beats a same-cycle clear
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ext_pend_q <= '0;
         // starts as active: a line already asserted at reset is no edge
         ext_prev_q <= '1;
         err_pend_q <= 1'b0;
         err_prev_q <= 1'b0;
      end else begin
         ext_prev_q <= ext_act;
         err_prev_q <= ERR_IRQ;
         for (int s = 0; s < `NUM_EXT; s++) begin
            if (sense_q[s]) begin
               ext_pend_q[s] <= ext_act[s];
            end else begin
               ext_pend_q[s] <= (ext_pend_q[s] && !clr_dist[s]) ||
                                (ext_act[s] && !ext_prev_q[s]);
            end
         end
         err_pend_q <= (err_pend_q && !clr_dist[`SRC_ERR]) || (ERR_IRQ && !err_prev_q);
      end
   end

   // pending latch, direct sources: one bit per processor, cleared apart
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         dir_pend_q <= '0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < `NUM_DIR; k++) begin
               logic ev;
               ev = (k < 4) ? (ipi_wr && w_data_q[k]) : TIMER_EVT[k - 4];
               dir_pend_q[c][k] <= (dir_pend_q[c][k] && !(ack_ok[c] &&
                                   hold_q[c].src == 5'(k + `SRC_DIR_LO))) ||
                                   (ev && dest_q[k + `SRC_DIR_LO][c]);
            end
         end
      end
   end

   // ==========================================================================
   // two-stage selector pipeline; hold freezes on the acknowledge cycle
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         st_q[0] <= '0;
         st_q[1] <= '0;
         hold_q[0] <= '0;
         hold_q[1] <= '0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            st_q[c] <= sel[c];
            if (!(ar_hs && ARADDR == ((c == 0) ? `OFS_ACK0 : `OFS_ACK1))) begin
               hold_q[c] <= st_q[c];
            end
         end
      end
   end

   // ==========================================================================
   // in-service tracker: set on acknowledge wins over a same-cycle clear
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         isr_q <= '0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            logic [39:0] set_m, clr_m;
            set_m = '0;
            clr_m = '0;
            if (ack_ok[c]) begin
               set_m[hold_q[c].pri - 4'h1] = 1'b1;
               set_m[`ISR_SRC_LSB + hold_q[c].src] = 1'b1;
            end
            if (eoi_wr[c] && eoi_pick[c].valid) begin
               clr_m[`ISR_SRC_LSB + eoi_pick[c].src] = 1'b1;
               clr_m[top_pri(isr_q[c][14:0]) - 4'h1] = 1'b1;
            end
            isr_q[c] <= (isr_q[c] & ~clr_m) | set_m;
         end
      end
   end

   // ==========================================================================
   // router: registered processor interrupt pins
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         IRQ_OUT <= '0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            logic above, ext, other_dest, other_busy, task_win;
            above = (hold_q[c].pri > top_pri(isr_q[c][14:0])) &&
                    (hold_q[c].pri > task_q[c]);
            ext = hold_q[c].src < 5'(`NUM_EXT);
            other_dest = dest_q[hold_q[c].src][1 - c];
            other_busy = isr_q[1 - c][`ISR_SRC_LSB + hold_q[c].src];
            // tie on task priority goes to processor 0 to avoid deadlock
            task_win = (c == 0) ? (task_q[0] <= task_q[1]) : (task_q[1] < task_q[0]);
            if (!hold_q[c].valid) begin
               IRQ_OUT[c] <= 1'b0;
            end else if (!ext) begin
               IRQ_OUT[c] <= above;
            end else if (!other_dest) begin
               IRQ_OUT[c] <= above;
            end else begin
               IRQ_OUT[c] <= above && !other_busy && task_win;
            end
         end
      end
   end

   // ==========================================================================
   // bus write channels, taken in either order
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         aw_v_q <= 1'b0;
         w_v_q <= 1'b0;
         bvalid_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else begin
         if (AWVALID && AWREADY) begin
            aw_v_q <= 1'b1;
            aw_addr_q <= AWADDR;
         end
         if (WVALID && WREADY) begin
            w_v_q <= 1'b1;
            w_data_q <= WDATA;
            w_strb_q <= WSTRB;
         end
         if (do_wr) begin
            aw_v_q <= 1'b0;
            w_v_q <= 1'b0;
            bvalid_q <= 1'b1;
         end else if (bvalid_q && BREADY) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // configuration registers; unmapped writes are answered and dropped
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mask_q <= {`NUM_SRC{`RST_MASK}};
         pol_q <= '0;
         sense_q <= '0;
         pri_q <= '0;
         vec_q <= '0;
         dest_q <= {`NUM_SRC{`RST_DEST}};
         task_q[0] <= `RST_TASK;
         task_q[1] <= `RST_TASK;
         spur_q <= `RST_SPUR;
      end else if (do_wr) begin
         for (int s = 0; s < `NUM_SRC; s++) begin
            logic [31:0] nw;
            nw = merge({mask_q[s], 7'h00, pol_q[s], sense_q[s], 2'h0, pri_q[s],
                        8'h00, vec_q[s]}, w_data_q, w_strb_q);
            if (aw_addr_q == 12'(s * 4)) begin
               mask_q[s] <= nw[`VP_MASK_BIT];
               pol_q[s] <= nw[`VP_POL_BIT];
               sense_q[s] <= nw[`VP_SENSE_BIT];
               pri_q[s] <= nw[`VP_PRI_LSB +: 4];
               vec_q[s] <= nw[`VP_VEC_LSB +: 8];
            end
            if (aw_addr_q == `OFS_DEST_BASE + 12'(s * 4) && w_strb_q[0]) begin
               dest_q[s] <= w_data_q[1:0];
            end
         end
         if (aw_addr_q == `OFS_TASK0 && w_strb_q[0]) begin
            task_q[0] <= w_data_q[3:0];
         end
         if (aw_addr_q == `OFS_TASK1 && w_strb_q[0]) begin
            task_q[1] <= w_data_q[3:0];
         end
         if (aw_addr_q == `OFS_SPUR && w_strb_q[0]) begin
            spur_q <= w_data_q[7:0];
         end
      end
   end

   // ==========================================================================
   // bus read: data one cycle after the address; unmapped reads give zero
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
         rdata_q <= '0;
         for (int s = 0; s < `NUM_SRC; s++) begin
            if (ARADDR == 12'(s * 4)) begin
               rdata_q <= {mask_q[s], 7'h00, pol_q[s], sense_q[s], 2'h0, pri_q[s],
                           8'h00, vec_q[s]};
            end
            if (ARADDR == `OFS_DEST_BASE + 12'(s * 4)) begin
               rdata_q <= {30'h0, dest_q[s]};
            end
         end
         case (ARADDR)
            `OFS_TASK0: rdata_q <= {28'h0, task_q[0]};
            `OFS_TASK1: rdata_q <= {28'h0, task_q[1]};
            // returned vector comes from the frozen hold register
            `OFS_ACK0: rdata_q <= {24'h0, ack_ok[0] ? vec_q[hold_q[0].src] : spur_q};
            `OFS_ACK1: rdata_q <= {24'h0, ack_ok[1] ? vec_q[hold_q[1].src] : spur_q};
            `OFS_STATUS: rdata_q <= {30'h0, IRQ_OUT};
            `OFS_ISR0_SRC: rdata_q <= {7'h0, isr_q[0][39:15]};
            `OFS_ISR1_SRC: rdata_q <= {7'h0, isr_q[1][39:15]};
            `OFS_ISR0_PRI: rdata_q <= {17'h0, isr_q[0][14:0]};
            `OFS_ISR1_PRI: rdata_q <= {17'h0, isr_q[1][14:0]};
            `OFS_SPUR: rdata_q <= {24'h0, spur_q};
            default: begin
            end
         endcase
      end else if (RREADY) begin
         rvalid_q <= 1'b0;
      end
   end
endmodule : irq_delivery

// [irq_delivery_properties.sv]
// bus handshake properties of the interrupt delivery block
`timescale 1ns/1ps
module irq_delivery_properties (
   // clock and reset
   input wire logic CLK,
   input wire logic ARST_N,
   // write side
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire irq_delivery_pkg::axi_resp_t BRESP,
   input wire logic BVALID,
   input wire logic BREADY,
   // read side
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic [31:0] RDATA,
   input wire irq_delivery_pkg::axi_resp_t RRESP,
   input wire logic RVALID,
   input wire logic RREADY,
   // interrupt outputs
   input wire logic [1:0] IRQ_OUT
);
   import irq_delivery_pkg::*;
   // ==========================================
   // one clock domain, so one default context
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);
   // ==========================================
   // read channel: answer one cycle after take
   chk_rd_answer: assert property (ARVALID && ARREADY |=> RVALID)
      else $error("read answer late");
   chk_rd_stands: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data not held");
   chk_rd_refused: assert property (RVALID |-> !ARREADY)
      else $error("read taken while busy");
   chk_rd_released: assert property (RVALID && RREADY |=> !RVALID)
      else $error("read answer repeated");
   chk_rd_okay: assert property (RVALID |-> RRESP == RESP_OKAY)
      else $error("read response not okay");
   // ==========================================
   // write channel: response after both halves
   chk_wr_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |=> ##1 BVALID)
      else $error("write answer late");
   chk_wr_stands: assert property (BVALID && !BREADY |=> BVALID)
      else $error("write answer dropped");
   chk_wr_refused: assert property (BVALID |-> !AWREADY && !WREADY)
      else $error("write taken while busy");
   chk_wr_okay: assert property (BVALID |-> BRESP == RESP_OKAY)
      else $error("write response not okay");
   // ==========================================
   // main scenarios reached
   cov_read: cover property (ARVALID && ARREADY);
   cov_write: cover property (BVALID && BREADY);
   cov_irq1: cover property ($rose(IRQ_OUT[1]));
endmodule : irq_delivery_properties

// [cpu_core_pair.sv]
// behavioural model of the two processor cores facing the interrupt lines
`timescale 1ns/1ps
module cpu_core_pair (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // interrupt lines and acknowledge notice
   input wire logic [1:0] irq,
   input wire logic [1:0] acked,
   // interrupt noticed per core
   output logic [1:0] seen
);
   // ==========================================
   // a core only acknowledges what it has seen;
   // set wins so a held line is not lost
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         seen <= 2'h0;
      end else begin
         seen <= (seen & ~acked) | irq;
      end
   end
endmodule : cpu_core_pair

// [tb.sv]
// self-checking bench of the interrupt delivery block
`timescale 1ns/1ps
module tb import irq_delivery_pkg::*;;
   logic CLK = 1'b0;
   logic ARST_N = 1'b0;
   logic [11:0] AWADDR = 12'h0, ARADDR = 12'h0;
   logic [31:0] WDATA = 32'h0, RDATA;
   logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
   axi_resp_t BRESP, RRESP;
   logic [15:0] EXT_IRQ = 16'h0;
   logic [3:0] TIMER_EVT = 4'h0;
   logic ERR_IRQ = 1'b0;
   logic [1:0] IRQ_OUT, seen, acked = 2'h0;
   int n_fail = 0, n_compared = 0;
   logic [31:0] d;
   irq_delivery i_irq_delivery (.CLK(CLK), .ARST_N(ARST_N), .AWADDR(AWADDR),
      .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID),
      .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
      .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
      .RREADY(RREADY), .EXT_IRQ(EXT_IRQ), .TIMER_EVT(TIMER_EVT), .ERR_IRQ(ERR_IRQ),
      .IRQ_OUT(IRQ_OUT));
   cpu_core_pair i_cpu_core_pair (.clk(CLK), .arst_n(ARST_N), .irq(IRQ_OUT), .acked(acked),
      .seen(seen));
   // ==========================================
   // 100 MHz clock
   initial begin
      forever #5 CLK = ~CLK;
   end
   // ==========================================
   // verdict, the single exit
   task end_of_test;
      if (n_fail == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
         n_fail++;
      end
   endtask : chk
   // settle point between edges; bounded so a hang ends the run
   task tick(inout int n);
      @(negedge CLK);
      n++;
      if (n > 60) begin
         $display("wrong value at %0t: no answer", $time);
         n_fail++;
         end_of_test();
      end
   endtask : tick
   // ==========================================
   // bus master tasks
   task wr(input logic [11:0] a, input logic [31:0] v);
      int n;
      logic aw, w;
      n = 0;
      aw = 1'b1;
      w = 1'b1;
      @(posedge CLK);
      AWADDR <= a;
      WDATA <= v;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      while (aw || w) begin
         tick(n);
         if (AWREADY === 1'b1) aw = 1'b0;
         if (WREADY === 1'b1) w = 1'b0;
         @(posedge CLK);
         AWVALID <= aw;
         WVALID <= w;
      end
      do tick(n); while (BVALID !== 1'b1);
      @(posedge CLK);
      BREADY <= 1'b0;
   endtask : wr
   task rd(input logic [11:0] a, output logic [31:0] v);
      int n;
      n = 0;
      @(posedge CLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do tick(n); while (ARREADY !== 1'b1);
      @(posedge CLK);
      ARVALID <= 1'b0;
      do tick(n); while (RVALID !== 1'b1);
      v = RDATA;
      @(posedge CLK);
      RREADY <= 1'b0;
   endtask : rd
   // a core answers a raised line with an acknowledge read
   task ack(input int c, input logic [7:0] v);
      rd(12'(12'h108 + 4 * c), d);
      chk({24'h0, d[7:0]}, {24'h0, v});
      // the core notices a line one edge after it rises, so look after the read
      chk({31'h0, seen[c]}, 32'h1);
      acked[c] <= 1'b1;
      @(posedge CLK);
      acked <= 2'h0;
   endtask : ack
   task wait_irq(input logic [1:0] e);
      int n;
      n = 0;
      while (IRQ_OUT !== e) tick(n);
      chk({30'h0, IRQ_OUT}, {30'h0, e});
   endtask : wait_irq
   task edge_src(input int s);
      @(posedge CLK);
      EXT_IRQ[s] <= 1'b1;
      @(posedge CLK);
      EXT_IRQ[s] <= 1'b0;
   endtask : edge_src
   // ==========================================
   // main sequence
   initial begin
      repeat (6) @(posedge CLK);
      ARST_N <= 1'b1;
      rd(12'h200, d);
      chk(d, 32'h0);
      // edge source to cpu0, then service cycle
      wr(12'h100, 32'h0);
      wr(12'h00c, 32'h0085_0033);
      repeat (4) @(posedge CLK);
      wait_irq(2'b00);
      edge_src(3);
      wait_irq(2'b01);
      ack(0, 8'h33);
      rd(12'h120, d);
      chk(d, 32'h8);
      rd(12'h128, d);
      chk(d, 32'h10);
      wait_irq(2'b00);
      rd(12'h108, d);
      chk(d[7:0], 8'hff);
      wr(12'h110, 32'h0);
      rd(12'h120, d);
      chk(d, 32'h0);
      // masked source keeps pending, wins once unmasked
      wr(12'h010, 32'h8086_0044);
      edge_src(4);
      edge_src(3);
      wait_irq(2'b01);
      wr(12'h010, 32'h0086_0044);
      repeat (4) @(posedge CLK);
      ack(0, 8'h44);
      wait_irq(2'b00);
      wr(12'h110, 32'h0);
      wait_irq(2'b01);
      ack(0, 8'h33);
      wr(12'h110, 32'h0);
      // level source follows its input
      wr(12'h018, 32'h00c7_0066);
      EXT_IRQ[6] <= 1'b1;
      wait_irq(2'b01);
      @(posedge CLK);
      EXT_IRQ[6] <= 1'b0;
      wait_irq(2'b00);
      rd(12'h108, d);
      chk(d[7:0], 8'hff);
      // priority zero never delivered
      wr(12'h01c, 32'h00c0_0077);
      EXT_IRQ[7] <= 1'b1;
      repeat (6) @(posedge CLK);
      wait_irq(2'b00);
      // both targets: tie to cpu0, lower task wins
      wr(12'h01c, 32'h00c3_0077);
      wr(12'h09c, 32'h3);
      wr(12'h104, 32'h0);
      wait_irq(2'b01);
      wr(12'h100, 32'h2);
      wr(12'h104, 32'h1);
      wait_irq(2'b10);
      ack(1, 8'h77);
      EXT_IRQ[7] <= 1'b0;
      wr(12'h114, 32'h0);
      // multicast cross-cpu source, cleared per core
      wr(12'h040, 32'h0009_0040);
      wr(12'h0c0, 32'h3);
      wr(12'h118, 32'h1);
      wait_irq(2'b11);
      ack(0, 8'h40);
      wait_irq(2'b10);
      ack(1, 8'h40);
      wr(12'h110, 32'h0);
      wr(12'h114, 32'h0);
      // timer event routed by destination
      wr(12'h050, 32'h000a_0050);
      wr(12'h0d0, 32'h2);
      @(posedge CLK);
      TIMER_EVT <= 4'h1;
      @(posedge CLK);
      TIMER_EVT <= 4'h0;
      wait_irq(2'b10);
      ack(1, 8'h50);
      // error source: distributed, edge-latched, routed as internal
      wr(12'h060, 32'h000b_0024);
      @(posedge CLK);
      ERR_IRQ <= 1'b1;
      @(posedge CLK);
      ERR_IRQ <= 1'b0;
      wait_irq(2'b01);
      ack(0, 8'h24);
      wait_irq(2'b00);
      end_of_test();
   end
endmodule : tb
bind irq_delivery irq_delivery_properties i_irq_delivery_properties (.CLK(CLK),
   .ARST_N(ARST_N), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
   .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
   .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .IRQ_OUT(IRQ_OUT));
